/* sfr_ctrl.sv */
`timescale 1ns/1ps
module sfr_ctrl #(
  parameter int unsigned FB_RETEST_MS  = sfr_pkg::FB_RETEST_MS,
  parameter int unsigned BYP_WINDOW_MS = sfr_pkg::BYP_WINDOW_MS,
  parameter int unsigned BYP_MAX_MS    = sfr_pkg::BYP_MAX_MS,
  parameter int unsigned BLINK_HALF_MS = sfr_pkg::BLINK_HALF_MS,
  parameter int unsigned MS_CYCLES     = sfr_pkg::MS_CYCLES
) (
  // clock and reset (reset = power-up)
  input  wire logic       clk,
  input  wire logic       arst_n,
  // configuration and beam state
  input  wire logic       auto_restart,
  input  wire logic       beams_aligned,
  // machine side pins
  input  wire logic       restart_btn,
  input  wire logic       restart_wire_ok,
  input  wire logic [1:0] output_readback,
  input  wire logic       output_short,
  input  wire logic       contactor_feedback_monitor,
  input  wire logic       bypass_req,
  input  wire logic [1:0] bypass_contact,
  input  wire logic [1:0] bypass_contact_nc,
  // safety outputs
  output logic [1:0]      safety_output_pair,
  // indicators
  output logic            fault_led,
  output logic            align_led_low,
  output logic            align_led_mid,
  output logic            align_led_high,
  output logic            bypass_led,
  output logic            wait_restart_led,
  output logic            outputs_active_led
);
  // -----------------------------------------------------------------
  // input synchronisation
  // -----------------------------------------------------------------
  logic [10:0] raw_in;
  logic [10:0] s_in;
  assign raw_in = {auto_restart, beams_aligned, restart_btn, restart_wire_ok,
                   output_readback, output_short, contactor_feedback_monitor,
                   bypass_req, bypass_contact[1], bypass_contact[0]};

  sfr_sync #(.W(11)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (raw_in),
    .q      (s_in)
  );

  logic       s_auto;
  logic       s_aligned;
  logic       s_btn;
  logic       s_wire_ok;
  logic [1:0] s_rdbk;
  logic       s_short;
  logic       s_fb;
  logic       s_byp_req;
  logic [1:0] s_byp;
  logic [1:0] s_byp_nc;
  assign s_auto    = s_in[10];
  assign s_aligned = s_in[9];
  assign s_btn     = s_in[8];
  assign s_wire_ok = s_in[7];
  assign s_rdbk    = s_in[6:5];
  assign s_short   = s_in[4];
  assign s_fb      = s_in[3];
  assign s_byp_req = s_in[2];
  assign s_byp     = s_in[1:0];

  sfr_sync #(.W(2)) u_sync_nc (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (bypass_contact_nc),
    .q      (s_byp_nc)
  );

  // -----------------------------------------------------------------
  // millisecond tick
  // -----------------------------------------------------------------
  logic [sfr_pkg::MS_CNT_W-1:0] ms_cnt_r;
  logic                          ms_tick;
  assign ms_tick = (ms_cnt_r == sfr_pkg::MS_CNT_W'(MS_CYCLES - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ms_cnt_r <= '0;
    else ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
  end

  // -----------------------------------------------------------------
  // blink generator
  // -----------------------------------------------------------------
  logic [sfr_pkg::SLOW_CNT_W-1:0] blink_cnt_r;
  logic                           blink_r;
  logic                           blink_end;
  assign blink_end = (blink_cnt_r == sfr_pkg::SLOW_CNT_W'(BLINK_HALF_MS - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (ms_tick) begin
      blink_cnt_r <= blink_end ? '0 : blink_cnt_r + 1'b1;
      if (blink_end) blink_r <= ~blink_r;
    end
  end

  // -----------------------------------------------------------------
  // power-up sampling window: first cycle with valid synced inputs
  // -----------------------------------------------------------------
  logic [1:0] pwr_cnt_r;
  logic       pwr_done;
  assign pwr_done = (pwr_cnt_r == 2'h3);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pwr_cnt_r <= 2'h0;
    else if (!pwr_done) pwr_cnt_r <= pwr_cnt_r + 2'h1;
  end

  // -----------------------------------------------------------------
  // restart state machine
  // -----------------------------------------------------------------
  sfr_pkg::sfr_state_t st_r;
  sfr_pkg::sfr_state_t st_nxt;
  sfr_pkg::sfr_fault_t flt_r;
  logic                locked;
  logic                outs_on;
  assign locked  = (flt_r != sfr_pkg::SFR_FLT_NONE);
  assign outs_on = (st_r == sfr_pkg::SFR_ST_ON);

  // feedback retest timer: auto mode re-examines feedback periodically
  logic [sfr_pkg::SLOW_CNT_W-1:0] retest_cnt_r;
  logic                           retest_due;
  assign retest_due = (retest_cnt_r == sfr_pkg::SLOW_CNT_W'(FB_RETEST_MS - 1)) && ms_tick;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) retest_cnt_r <= '0;
    else if (st_r != sfr_pkg::SFR_ST_OFF) retest_cnt_r <= '0;
    else if (ms_tick) retest_cnt_r <= retest_due ? '0 : retest_cnt_r + 1'b1;
  end

  // feedback closed means contactor released, a precondition for auto restart only; the manual path does not test it
  logic ready;
  assign ready = s_aligned && !locked && pwr_done;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      sfr_pkg::SFR_ST_OFF: begin
        if (ready && s_auto && s_fb && retest_due)
          st_nxt = sfr_pkg::SFR_ST_ON;
        else if (ready && !s_auto) st_nxt = sfr_pkg::SFR_ST_WAIT;
      end
      sfr_pkg::SFR_ST_WAIT: begin
        if (!ready || s_auto) st_nxt = sfr_pkg::SFR_ST_OFF;
        else if (s_btn) st_nxt = sfr_pkg::SFR_ST_PRESSED;
      end
      sfr_pkg::SFR_ST_PRESSED: begin
        if (!ready) st_nxt = sfr_pkg::SFR_ST_OFF;
        else if (!s_btn) st_nxt = sfr_pkg::SFR_ST_ON;
      end
      sfr_pkg::SFR_ST_ON: begin
        if (!ready) st_nxt = sfr_pkg::SFR_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_r <= sfr_pkg::SFR_ST_OFF;
    else st_r <= st_nxt;
  end

  // -----------------------------------------------------------------
  // bypass supervision
  // -----------------------------------------------------------------
  logic [sfr_pkg::SLOW_CNT_W-1:0] skew_cnt_r;
  logic [sfr_pkg::SLOW_CNT_W-1:0] byp_on_cnt_r;
  logic                           one_closed;
  logic                           both_closed;
  logic                           skew_err;
  logic                           maxtime_err;
  logic                           contact_err;
  assign one_closed  = s_byp[0] ^ s_byp[1];
  assign both_closed = &s_byp;
  assign skew_err    = one_closed && ms_tick &&
                       (skew_cnt_r == sfr_pkg::SLOW_CNT_W'(BYP_WINDOW_MS - 1));
  assign maxtime_err = both_closed && ms_tick &&
                       (byp_on_cnt_r == sfr_pkg::SLOW_CNT_W'(BYP_MAX_MS - 1));
  // companion contact must be the inverse of the working one while bypass is requested
  assign contact_err = pwr_done && ((s_byp[0] == s_byp_nc[0]) ||
                                    (s_byp[1] == s_byp_nc[1]));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skew_cnt_r   <= '0;
      byp_on_cnt_r <= '0;
    end else begin
      if (!one_closed) skew_cnt_r <= '0;
      else if (ms_tick && !skew_err) skew_cnt_r <= skew_cnt_r + 1'b1;
      if (!both_closed) byp_on_cnt_r <= '0;
      else if (ms_tick && !maxtime_err) byp_on_cnt_r <= byp_on_cnt_r + 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // error detection
  // -----------------------------------------------------------------
  logic restart_err;
  logic output_err;
  logic feedback_err;
  logic bypass_err;
  logic first_chk;
  assign first_chk    = (pwr_cnt_r == 2'h2);
  assign restart_err  = (first_chk && s_btn) || (pwr_done && !s_wire_ok);
  // readback is held against the level driven two cycles earlier, the
  // synchroniser delay, so a normal switch-on never looks like a fault;
  // a load slower than that still trips it
  logic [1:0] cmd_d1_r;
  logic [1:0] cmd_d2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_d1_r <= 2'h0;
      cmd_d2_r <= 2'h0;
    end else begin
      cmd_d1_r <= safety_output_pair;
      cmd_d2_r <= cmd_d1_r;
    end
  end

  assign output_err   = pwr_done && (s_short || (s_rdbk != cmd_d2_r));
  assign feedback_err = outs_on && !s_fb;
  assign bypass_err   = s_byp_req && (skew_err || maxtime_err || contact_err);

  // first fault wins and sticks until power is removed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) flt_r <= sfr_pkg::SFR_FLT_NONE;
    else if (!locked) begin
      if (restart_err) flt_r <= sfr_pkg::SFR_FLT_RESTART;
      else if (output_err) flt_r <= sfr_pkg::SFR_FLT_OUTPUT;
      else if (feedback_err) flt_r <= sfr_pkg::SFR_FLT_FEEDBACK;
      else if (bypass_err) flt_r <= sfr_pkg::SFR_FLT_BYPASS;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  logic [1:0] outs_nxt;
  logic       led_fault_nxt;
  logic       led_low_nxt;
  logic       led_mid_nxt;
  logic       led_high_nxt;
  logic       led_byp_nxt;
  logic       led_wait_nxt;
  logic       led_act_nxt;
  assign outs_nxt      = (outs_on && !locked) ? 2'h3 : 2'h0;
  assign led_fault_nxt = locked;
  assign led_low_nxt   = locked ? (flt_r == sfr_pkg::SFR_FLT_RESTART) && blink_r
                                : (s_aligned && !outs_on);
  assign led_mid_nxt   = locked ? (flt_r == sfr_pkg::SFR_FLT_OUTPUT) && blink_r
                                : (s_aligned && !outs_on);
  assign led_high_nxt  = locked ? (flt_r == sfr_pkg::SFR_FLT_FEEDBACK) && blink_r
                                : (s_aligned && !outs_on);
  assign led_byp_nxt   = locked ? (flt_r == sfr_pkg::SFR_FLT_BYPASS) && blink_r
                                : (s_byp_req && both_closed);
  assign led_wait_nxt  = !locked && s_aligned &&
                         (st_r == sfr_pkg::SFR_ST_WAIT ||
                          st_r == sfr_pkg::SFR_ST_PRESSED);
  assign led_act_nxt   = outs_on && !locked;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      safety_output_pair <= 2'h0;
      fault_led          <= 1'b0;
      align_led_low      <= 1'b0;
      align_led_mid      <= 1'b0;
      align_led_high     <= 1'b0;
      bypass_led         <= 1'b0;
      wait_restart_led   <= 1'b0;
      outputs_active_led <= 1'b0;
    end else begin
      safety_output_pair <= outs_nxt;
      fault_led          <= led_fault_nxt;
      align_led_low      <= led_low_nxt;
      align_led_mid      <= led_mid_nxt;
      align_led_high     <= led_high_nxt;
      bypass_led         <= led_byp_nxt;
      wait_restart_led   <= led_wait_nxt;
      outputs_active_led <= led_act_nxt;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_press_release;
    st_r == sfr_pkg::SFR_ST_PRESSED ##1 st_r == sfr_pkg::SFR_ST_ON;
  endsequence

  AST_LOCK_STICKS: assert property (@(posedge clk) disable iff (!arst_n)
    locked |=> locked && $stable(flt_r))
    else $error("lockout cleared or fault code changed");
  AST_LOCK_OUTS_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    locked |=> safety_output_pair == 2'h0 && !outputs_active_led)
    else $error("outputs active during lockout");
  AST_RESTART_PAT: assert property (@(posedge clk) disable iff (!arst_n)
    flt_r == sfr_pkg::SFR_FLT_RESTART |=> fault_led && !align_led_mid && !bypass_led)
    else $error("restart fault pattern wrong");
  AST_FB_ERR: assert property (@(posedge clk) disable iff (!arst_n)
    (!locked && outs_on && !s_fb) |=> flt_r != sfr_pkg::SFR_FLT_NONE)
    else $error("feedback open with outputs on not latched");
  AST_PWR_BTN: assert property (@(posedge clk) disable iff (!arst_n)
    (first_chk && s_btn && !locked) |=> flt_r == sfr_pkg::SFR_FLT_RESTART)
    else $error("button at power-up not flagged");
  AST_PRESS_ON: assert property (@(posedge clk) disable iff (!arst_n)
    s_press_release |=> outputs_active_led && !wait_restart_led)
    else $error("press-release did not enable outputs");
  AST_WAIT_OFF_BROKEN: assert property (@(posedge clk) disable iff (!arst_n)
    !s_aligned |=> !wait_restart_led)
    else $error("wait indicator lit with beam broken");
  AST_BLINK_HALF: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(blink_r) |-> blink_cnt_r == '0 && $past(ms_tick))
    else $error("blink toggled off the half-period");
  AST_MANUAL_ONLY_BTN: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == sfr_pkg::SFR_ST_WAIT && !s_btn) |=> st_r != sfr_pkg::SFR_ST_ON)
    else $error("manual mode enabled without press");
endmodule

/* sfr_pkg.sv */
package sfr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned FB_RETEST_S     = 15;
  localparam int unsigned BYP_WINDOW_MS   = 300;
  localparam int unsigned BYP_MAX_MS      = 60000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  // half blink period in milliseconds; blink toggles every half period
  localparam int unsigned BLINK_HALF_MS   = BLINK_PERIOD_MS / 2;
  localparam int unsigned FB_RETEST_MS    = FB_RETEST_S * 1000;
  localparam int unsigned MS_CNT_W        = 18;
  localparam int unsigned SLOW_CNT_W      = 17;

  // ---------------------------------------------------------------
  // fault codes and restart states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SFR_FLT_NONE,
    SFR_FLT_RESTART,
    SFR_FLT_OUTPUT,
    SFR_FLT_FEEDBACK,
    SFR_FLT_BYPASS
  } sfr_fault_t;

  typedef enum logic [1:0] {
    SFR_ST_OFF,
    SFR_ST_WAIT,
    SFR_ST_PRESSED,
    SFR_ST_ON
  } sfr_state_t;
endpackage

/* sfr_sync.sv */
`timescale 1ns/1ps
module sfr_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // -----------------------------------------------------------------
  // two-stage synchroniser
  // -----------------------------------------------------------------
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* sfr_machine_model.sv */
`timescale 1ns/1ps
module sfr_machine_model (
  // clock
  input  wire logic       clk,
  // bench controls
  input  wire logic       btn_cmd,
  input  wire logic       fb_open,
  input  wire logic       rb_stuck,
  input  wire logic [1:0] byp_cmd,
  input  wire logic       nc_bad,
  // device side
  input  wire logic [1:0] safety_output_pair,
  output logic            restart_btn,
  output logic [1:0]      output_readback,
  output logic            contactor_feedback_monitor,
  output logic [1:0]      bypass_contact,
  output logic [1:0]      bypass_contact_nc
);
  // ---------------------------------------------------------------
  // contacts
  // ---------------------------------------------------------------
  // contacts settle one clock after the command, like a slow relay
  always_ff @(posedge clk) begin
    restart_btn                <= btn_cmd;
    contactor_feedback_monitor <= ~fb_open;
    bypass_contact             <= byp_cmd;
    bypass_contact_nc          <= nc_bad ? byp_cmd : ~byp_cmd;
  end
  // when stuck, both channels read high whatever is commanded
  assign output_readback = rb_stuck ? 2'h3 : safety_output_pair;
endmodule

/* safety_curtain_fault_restart_ctrl_tb.sv */
`timescale 1ns/1ps
module safety_curtain_fault_restart_ctrl_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int A = 0, W = 1, B = 2, H = 3, M = 4, L = 5, F = 6;
  logic       clk, arst_n, auto_md, algn, wire_ok, short, req;
  logic       btn, fbo, stk, ncb;
  logic [1:0] byp;
  logic       rbtn, fbm, fled, lo, mid, hi, bled, wled, aled;
  logic [1:0] rdbk, bc, bnc, pair;
  logic [8:0] obs;
  int         n_fail, check_count, cyc;
  assign obs = {pair, fled, lo, mid, hi, bled, wled, aled};

  sfr_ctrl #(.FB_RETEST_MS(5), .BYP_WINDOW_MS(3), .BYP_MAX_MS(20),
    .BLINK_HALF_MS(2), .MS_CYCLES(4)) DUT (
    .clk(clk), .arst_n(arst_n), .auto_restart(auto_md), .beams_aligned(algn),
    .restart_btn(rbtn), .restart_wire_ok(wire_ok), .output_readback(rdbk),
    .output_short(short), .contactor_feedback_monitor(fbm), .bypass_req(req),
    .bypass_contact(bc), .bypass_contact_nc(bnc), .safety_output_pair(pair),
    .fault_led(fled), .align_led_low(lo), .align_led_mid(mid),
    .align_led_high(hi), .bypass_led(bled), .wait_restart_led(wled),
    .outputs_active_led(aled));

  sfr_machine_model u_mach (
    .clk(clk), .btn_cmd(btn), .fb_open(fbo), .rb_stuck(stk), .byp_cmd(byp),
    .nc_bad(ncb), .safety_output_pair(pair), .restart_btn(rbtn),
    .output_readback(rdbk), .contactor_feedback_monitor(fbm),
    .bypass_contact(bc), .bypass_contact_nc(bnc));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [1:0] s, input logic [1:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task chkb(input int i, input logic v);
    chk({1'b0, obs[i]}, {1'b0, v});
  endtask

  // bounded wait for an indicator level, then compare it
  task wt(input int i, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && obs[i] !== v; k++) @(negedge clk);
    chkb(i, v);
  endtask

  // half blink period is 2 ms of 4 cycles each
  task blink(input int i);
    logic s;
    int   k;
    s = obs[i];
    for (k = 0; k < 40 && obs[i] === s; k++) @(negedge clk);
    s = obs[i];
    for (k = 0; k < 40 && obs[i] === s; k++) @(negedge clk);
    chk({1'b0, k == 8}, 2'h1);
  endtask

  task lock(input int i);
    wt(F, 1'b1, 60);
    blink(i);
    chk(obs[8:7], 2'h0);
    chkb(A, 1'b0);
  endtask

  // power cycle: mode a, restart button held b
  task pwr(input logic a, input logic b);
    arst_n  = 1'b0;
    auto_md = a;
    algn    = 1'b1;
    wire_ok = 1'b1;
    short   = 1'b0;
    req     = 1'b0;
    btn     = b;
    fbo     = 1'b0;
    stk     = 1'b0;
    ncb     = 1'b0;
    byp     = 2'h0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, timeout, sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end

  initial begin
    pwr(1'b0, 1'b0);
    wt(W, 1'b1, 40);
    algn = 1'b0;
    repeat (8) @(negedge clk);
    chkb(W, 1'b0);
    algn = 1'b1;
    wt(W, 1'b1, 40);
    chkb(A, 1'b0);
    btn = 1'b1;
    repeat (6) @(negedge clk);
    btn = 1'b0;
    wt(A, 1'b1, 30);
    chk(obs[8:7], 2'h3);
    chkb(W, 1'b0);
    algn = 1'b0;
    repeat (12) @(negedge clk);
    chkb(W, 1'b0);
    // auto mode holds off while feedback is open at the retest
    pwr(1'b1, 1'b0);
    fbo = 1'b1;
    repeat (50) @(negedge clk);
    chkb(A, 1'b0);
    fbo = 1'b0;
    wt(A, 1'b1, 60);
    chk(obs[8:7], 2'h3);
    fbo = 1'b1;
    lock(H);
    fbo   = 1'b0;
    short = 1'b1;
    repeat (100) @(negedge clk);
    chkb(F, 1'b1);
    chkb(M, 1'b0);
    blink(H);
    pwr(1'b0, 1'b1);
    lock(L);
    pwr(1'b0, 1'b0);
    wire_ok = 1'b0;
    lock(L);
    pwr(1'b0, 1'b0);
    short = 1'b1;
    lock(M);
    pwr(1'b0, 1'b0);
    stk = 1'b1;
    lock(M);
    pwr(1'b0, 1'b0);
    req = 1'b1;
    byp = 2'h1;
    repeat (30) @(negedge clk);
    byp = 2'h3;
    lock(B);
    pwr(1'b0, 1'b0);
    req = 1'b1;
    byp = 2'h3;
    wt(B, 1'b1, 20);
    repeat (45) @(negedge clk);
    chkb(F, 1'b0);
    lock(B);
    pwr(1'b0, 1'b0);
    req = 1'b1;
    ncb = 1'b1;
    lock(B);
    end_of_test;
  end
endmodule
